// ### src/arrs_top.sv
// arrs_top: result formatting, reference and input selection registers
// assumes the analog core gives a busy level and a one-cycle done pulse with
// a raw signed or unsigned 10-bit code, all on i_clk
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
module arrs_top (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_conv_busy,
  input  wire logic       i_conv_done,
  input  wire logic [9:0] i_conv_code,
  input  wire logic       i_analog_en,
  input  wire logic       i_vector_ack,
  output logic      [7:0] o_rdata,
  output logic      [1:0] o_ref_sel,
  output logic      [3:0] o_chan_sel,
  output logic            o_int_ref_on,
  output logic            o_irq
);
  typedef struct packed {
    logic [7:0] sel;       // software view of input select
    logic [1:0] ref_act;   // selection used by the converter
    logic [3:0] chan_act;
    logic [9:0] result;
    logic       done;
    logic       mask;
    logic       int_ref;
    logic       irq;
    logic [7:0] rdata;
  } arrs_state_type;

  arrs_state_type s_q;
  arrs_state_type s_d;
  logic [7:0]     res_high;
  logic [7:0]     res_low;
  logic           left_align;

  assign left_align = s_q.sel[arrs_pkg::LEFT_ALIGN_POS];

  // alignment is applied at read time so a change re-maps at once
  arrs_align u_align (
    .i_result     (s_q.result),
    .i_left_align (left_align),
    .o_high       (res_high),
    .o_low        (res_low)
  );

  // next-state logic for registers, selection lock and flag
  always_comb begin
    s_d = s_q;
    if (i_wr && i_addr == arrs_pkg::ADDR_INPUT_SEL) begin
      s_d.sel = i_wdata;
    end
    if (i_wr && i_addr == arrs_pkg::ADDR_MASK) begin
      s_d.mask = i_wdata[arrs_pkg::DONE_FLAG_POS];
    end
    // selection follows software only while idle or at completion
    if (!i_conv_busy || i_conv_done) begin
      s_d.ref_act  = s_d.sel[arrs_pkg::REF_SEL_HI_POS:
                             arrs_pkg::REF_SEL_LO_POS];
      s_d.chan_act = s_d.sel[arrs_pkg::CHAN_SEL_MSB:0];
    end
    // core code is already unsigned or two's complement; stored as is
    if (i_conv_done) begin
      s_d.result = i_conv_code;
    end
    // clear by write-one or vector ack; a done pulse wins over the clear
    if ((i_wr && i_addr == arrs_pkg::ADDR_STATUS &&
         i_wdata[arrs_pkg::DONE_FLAG_POS]) || i_vector_ack) begin
      s_d.done = 1'b0;
    end
    if (i_conv_done) begin
      s_d.done = 1'b1;
    end
    s_d.int_ref = (s_d.ref_act == arrs_pkg::REF_INTERNAL) &&
                  i_analog_en;
    s_d.irq = s_d.done && s_d.mask;
    s_d.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        arrs_pkg::ADDR_INPUT_SEL:   s_d.rdata = s_q.sel;
        arrs_pkg::ADDR_RESULT_LOW:  s_d.rdata = res_low;
        arrs_pkg::ADDR_RESULT_HIGH: s_d.rdata = res_high;
        arrs_pkg::ADDR_STATUS:      s_d.rdata = {7'h00, s_q.done};
        arrs_pkg::ADDR_MASK:        s_d.rdata = {7'h00, s_q.mask};
        default:                    s_d.rdata = 8'h00;
      endcase
    end
  end

  // single register stage for all state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.sel <= arrs_pkg::INPUT_SEL_RESET;
      s_q.result <= arrs_pkg::RESULT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata      = s_q.rdata;
  assign o_ref_sel    = s_q.ref_act;
  assign o_chan_sel   = s_q.chan_act;
  assign o_int_ref_on = s_q.int_ref;
  assign o_irq        = s_q.irq;

  a_done_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_conv_done |=> s_q.done) else $error("done flag not set");
  a_result_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_conv_done |=> s_q.result == $past(i_conv_code))
    else $error("result not loaded");
  a_ref_locked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_conv_busy && !i_conv_done) |=> $stable(o_ref_sel))
    else $error("reference changed mid conversion");
  a_ref_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_conv_busy && !i_wr) |=> o_ref_sel == s_q.sel[7:6])
    else $error("reference not following select");
  a_int_ref: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_int_ref_on == ($past(i_analog_en) &&
                          o_ref_sel == arrs_pkg::REF_INTERNAL))
    else $error("internal reference power wrong");
  a_high_left: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == arrs_pkg::ADDR_RESULT_HIGH && left_align)
    |=> o_rdata == $past(s_q.result[9:2]))
    else $error("left high byte wrong");
  a_low_right: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == arrs_pkg::ADDR_RESULT_LOW && !left_align)
    |=> o_rdata == $past(s_q.result[7:0]))
    else $error("right low byte wrong");
  a_sign_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == arrs_pkg::ADDR_RESULT_HIGH)
    |=> o_rdata[$past(left_align) ? 7 : 1] == $past(s_q.result[9]))
    else $error("sign bit not in high byte");
  a_clear_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == arrs_pkg::ADDR_STATUS && i_wdata[0] &&
     !i_conv_done) |=> !s_q.done) else $error("done not cleared");
  c_done: cover property (@(posedge i_clk) i_conv_done ##1 o_irq);
  c_defer: cover property (@(posedge i_clk)
    (i_conv_busy && i_wr && i_addr == arrs_pkg::ADDR_INPUT_SEL)
    ##[1:50] i_conv_done);
  c_realign: cover property (@(posedge i_clk)
    s_q.done && i_wr && i_addr == arrs_pkg::ADDR_INPUT_SEL);
endmodule

// ### shared/arrs_pkg.sv
// arrs_pkg: constants and types for the converter result and reference block
// assumes a byte-wide register port with read data one cycle after the strobe
package arrs_pkg;
  // register byte addresses
  localparam logic [2:0] ADDR_INPUT_SEL   = 3'h0;
  localparam logic [2:0] ADDR_RESULT_LOW  = 3'h1;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_STATUS      = 3'h3;
  localparam logic [2:0] ADDR_MASK        = 3'h4;
  // input select register field positions
  localparam int REF_SEL_HI_POS  = 7;
  localparam int REF_SEL_LO_POS  = 6;
  localparam int LEFT_ALIGN_POS  = 5;
  localparam int CHAN_SEL_MSB    = 3;
  // status bit positions
  localparam int DONE_FLAG_POS   = 0;
  // reset values
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET    = 10'h000;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  // reference select codes
  typedef enum logic [1:0] {
    REF_PIN       = 2'h0,
    REF_SUPPLY    = 2'h1,
    REF_RESERVED  = 2'h2,
    REF_INTERNAL  = 2'h3
  } arrs_ref_type;
  // channel codes with special meaning
  localparam logic [3:0] CHAN_LAST_SINGLE = 4'hA;
  localparam logic [3:0] CHAN_AMP0        = 4'hB;
  localparam logic [3:0] CHAN_AMP1        = 4'hC;
  localparam logic [3:0] CHAN_RESERVED    = 4'hD;
  localparam logic [3:0] CHAN_BANDGAP     = 4'hE;
  localparam logic [3:0] CHAN_GROUND      = 4'hF;
endpackage

// ### src/arrs_align.sv
// arrs_align: places a 10-bit result into the high and low result bytes
// assumes a purely combinational use by the register block
module arrs_align (
  input  wire logic [9:0] i_result,
  input  wire logic       i_left_align,
  output logic      [7:0] o_high,
  output logic      [7:0] o_low
);
  // left: 9..2 high, 1..0 at top of low; right: 9..8 high, 7..0 low
  always_comb begin
    if (i_left_align) begin
      o_high = i_result[9:2];
      o_low  = {i_result[1:0], 6'h00};
    end else begin
      o_high = {6'h00, i_result[9:8]};
      o_low  = i_result[7:0];
    end
  end
endmodule

// ### sim/arrs_tb.sv
// testbench: drives the converter register block through its byte port
// assumes arrs_top with a busy level and a one-cycle done pulse from the core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk, i_sys_rst, i_wr, i_rd, i_conv_busy, i_conv_done;
  logic       i_analog_en, i_vector_ack, o_int_ref_on, o_irq;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [9:0] i_conv_code;
  logic [1:0] o_ref_sel;
  logic [3:0] o_chan_sel;
  int         fails = 0;
  int         n_tests = 0;
  arrs_top u_arrs_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_conv_busy(i_conv_busy), .i_conv_done(i_conv_done),
    .i_conv_code(i_conv_code), .i_analog_en(i_analog_en),
    .i_vector_ack(i_vector_ack), .o_rdata(o_rdata), .o_ref_sel(o_ref_sel),
    .o_chan_sel(o_chan_sel), .o_int_ref_on(o_int_ref_on), .o_irq(o_irq));
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // core finishes: done pulse with the code, busy drops as the pulse ends; no
  // converter pin is toggled while busy, so accuracy is kept
  task automatic conv(input logic [9:0] c);
    @(posedge i_clk);
    i_conv_done <= 1'b1;
    i_conv_code <= c;
    @(posedge i_clk);
    i_conv_done <= 1'b0;
    i_conv_busy <= 1'b0;
  endtask
  // differential code read left then right aligned, then full scale
  task automatic t_result;
    wr(3'h0, 8'h20);
    conv(10'h270);
    rd(3'h2, 8'h9C);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    rd(3'h2, 8'h02);
    rd(3'h1, 8'h70);
    conv(10'h3FF);
    rd(3'h1, 8'hFF);
    rd(3'h2, 8'h03);
    rd(3'h7, 8'h00);
  endtask
  // flag raises the line when unmasked, cleared by write one and by ack
  task automatic t_irq;
    wr(3'h4, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk({7'h00, o_irq}, 8'h01);
    rd(3'h3, 8'h01);
    wr(3'h3, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk({7'h00, o_irq}, 8'h00);
    conv(10'h201);
    @(posedge i_clk) i_vector_ack <= 1'b1;
    @(posedge i_clk) i_vector_ack <= 1'b0;
    rd(3'h3, 8'h00);
  endtask
  // internal reference, then a change held off until the conversion ends
  task automatic t_ref;
    wr(3'h0, 8'hCE);
    i_analog_en <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({2'h0, o_ref_sel, o_chan_sel}, 8'h3E);
    chk({7'h00, o_int_ref_on}, 8'h01);
    @(posedge i_clk) i_conv_busy <= 1'b1;
    wr(3'h0, 8'h4B);
    repeat (2) @(posedge i_clk);
    #1 chk({2'h0, o_ref_sel, o_chan_sel}, 8'h3E);
    conv(10'h000);
    repeat (2) @(posedge i_clk);
    #1 chk({2'h0, o_ref_sel, o_chan_sel}, 8'h1B);
    rd(3'h0, 8'h4B);
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the sequence needs well under a microsecond
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  // main sequence
  initial begin
    {i_wr, i_rd, i_conv_busy, i_conv_done, i_analog_en} = 5'h00;
    {i_vector_ack, i_addr, i_wdata, i_conv_code} = 22'h000000;
    i_sys_rst = 1'b1;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(3'h0, 8'h00);
    t_result();
    t_irq();
    t_ref();
    end_sim();
  end
endmodule
